// ### inc/start_logic_pkg.sv
// Package for the sensorless start-condition logic.
// Assumes one 100 MHz clock and a 32-bit APB register port.
package start_logic_pkg;

  // Register byte offsets
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] BEMF_CODE_OFFSET = 12'h004;
  localparam logic [11:0] BEMF_DIGITAL_OFFSET = 12'h008;
  localparam logic [11:0] STATUS_OFFSET = 12'h00C;

  // Control register field positions
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_SPEED_DETECT_BIT = 1;
  localparam int CTRL_RESYNC_BIT = 2;
  localparam int CTRL_REVERSE_DRIVE_BIT = 3;
  localparam int CTRL_BRAKE_BIT = 4;
  localparam int CTRL_PROBE_METHOD_BIT = 5;
  localparam int CTRL_ALIGN_PHASE_LSB = 6;
  localparam int CTRL_THRESHOLD_LSB = 8;
  localparam int CTRL_WIDTH = 10;
  localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 10'h000;

  // Back-EMF code layout: shift above mantissa
  localparam int BEMF_CODE_WIDTH = 7;
  localparam int BEMF_MANTISSA_WIDTH = 4;
  localparam int BEMF_DIGITAL_WIDTH = 11;
  localparam logic [BEMF_CODE_WIDTH-1:0] BEMF_CODE_RESET = 7'h00;
  // One digital step is 0.92 mV/Hz, i.e. 1090 steps per V/Hz
  localparam int BEMF_LSB_UV_PER_HZ = 920;
  localparam int BEMF_STEPS_PER_V_PER_HZ = 1090;
  localparam logic [BEMF_DIGITAL_WIDTH-1:0] BEMF_DIGITAL_MAX = 11'h780;

  // Status field positions
  localparam int STATUS_CLASS_LSB = 4;
  localparam int STATUS_SECTOR_LSB = 6;

  // Speed compare thresholds picked by the 2-bit threshold field
  localparam int SPEED_WIDTH = 16;
  localparam logic [3:0][SPEED_WIDTH-1:0] SPEED_THRESHOLDS = {16'h0200, 16'h0100, 16'h0080, 16'h0040};

  // Forced alignment hold time
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int ALIGN_TIME_NS = 20000;
  localparam int ALIGN_CYCLES = (ALIGN_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int ALIGN_COUNT_WIDTH = 12;

  // Start sequencer states
  typedef enum logic [3:0] {
    SEQ_POWER_ON, SEQ_MEASURE, SEQ_AT_REST, SEQ_PROBE, SEQ_ALIGN,
    SEQ_CLOSED_LOOP, SEQ_REVERSE_DRIVE, SEQ_BRAKE, SEQ_WAIT_STOP
  } seq_state_type;

  // Rotor condition found before start
  typedef enum logic [1:0] {
    ROTOR_UNKNOWN, ROTOR_REST, ROTOR_FORWARD, ROTOR_REVERSE
  } rotor_class_type;

endpackage : start_logic_pkg

// ### core/sensorless_start_condition_logic.sv
// Start-up decision logic for a sensorless three-phase motor driver.
// Assumes speed, direction and stop indications from the analog front end,
// synchronous to clk, and an APB master for configuration.
//
// How it works
// - Code is 3-bit shift over 4-bit mantissa
// - Classify rotor: rest, forward or reverse
// - At rest, set commutation to rotor position
// - Rest start selectable: position detect or align
// - Position detect uses winding inductance variation
// - Align energises one phase before commutation
// - Fast forward rotor may resync into closed loop
// - Reverse drive decelerates through zero forward
// - Without reverse drive, brake or wait
// - Stopped rotor continues the at-rest path
// - Digital constant is mantissa shifted by shift
// - Sequencer restarts at power-up and wake
// - Speed measured only when detection enabled
// - Below threshold speed counts as rest
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none

module sensorless_start_condition_logic
  import start_logic_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Power state
  input wire logic wake,
  // Speed detector
  input wire logic speedValid,
  input wire logic [SPEED_WIDTH-1:0] measuredSpeed,
  input wire logic spinForward,
  input wire logic rotorStopped,
  input wire logic zeroCrossed,
  // Position detector
  input wire logic probeDone,
  input wire logic [2:0] probeSector,
  // Drive commands
  output logic measureRun,
  output logic probeRun,
  output logic alignRun,
  output logic [1:0] alignPhase,
  output logic closedLoop,
  output logic reverseDriveOn,
  output logic brakeOn,
  output logic [2:0] commutationSector,
  output logic [BEMF_DIGITAL_WIDTH-1:0] bemfDigital
);

  //////////////////////////////////////////////////////////////////////////////
  // State record

  // All flops of the block
  typedef struct packed {
    seq_state_type seqState;  // Sequencer state
    rotor_class_type rotorClass;  // Last classification
    logic [CTRL_WIDTH-1:0] ctrl;  // Control register
    logic [BEMF_CODE_WIDTH-1:0] bemfCode;  // Back-EMF code
    logic [BEMF_DIGITAL_WIDTH-1:0] bemfDig;  // Decoded constant
    logic [2:0] sector;  // Commutation sector
    logic [ALIGN_COUNT_WIDTH-1:0] alignCount;  // Align hold counter
    logic [31:0] readData;  // Read data for access phase
  } core_state_type;

  core_state_type state_reg;  // Registered state
  core_state_type state_next;  // Next state

  // Decoded control bits
  logic startEnable;
  logic speedDetectEnable;
  logic resyncEnable;
  logic reverseEnable;
  logic brakeEnable;
  logic probeMethod;
  logic [1:0] stationary_speed_threshold;
  logic [SPEED_WIDTH-1:0] speedLimit;
  logic rotorFast;  // Measured speed at or above threshold
  logic setupPhase;  // APB setup cycle
  logic writeAccess;  // APB write access cycle
  logic addrMapped;  // Address hits a register
  logic [BEMF_MANTISSA_WIDTH-1:0] bemf_const_mantissa;
  logic [2:0] bemf_const_shift;

  //////////////////////////////////////////////////////////////////////////////
  // Field decode

  assign startEnable = state_reg.ctrl[CTRL_START_BIT];
  assign speedDetectEnable = state_reg.ctrl[CTRL_SPEED_DETECT_BIT];
  assign resyncEnable = state_reg.ctrl[CTRL_RESYNC_BIT];
  assign reverseEnable = state_reg.ctrl[CTRL_REVERSE_DRIVE_BIT];
  assign brakeEnable = state_reg.ctrl[CTRL_BRAKE_BIT];
  assign probeMethod = state_reg.ctrl[CTRL_PROBE_METHOD_BIT];
  assign stationary_speed_threshold = state_reg.ctrl[CTRL_THRESHOLD_LSB +: 2];
  assign speedLimit = SPEED_THRESHOLDS[stationary_speed_threshold];
  assign rotorFast = (measuredSpeed >= speedLimit);
  // Code splits into shift (top) and mantissa (bottom)
  assign bemf_const_mantissa = state_reg.bemfCode[BEMF_MANTISSA_WIDTH-1:0];
  assign bemf_const_shift = state_reg.bemfCode[BEMF_CODE_WIDTH-1:BEMF_MANTISSA_WIDTH];

  assign setupPhase = psel && !penable;
  assign writeAccess = psel && penable && pwrite;
  assign addrMapped = (paddr == CTRL_OFFSET) || (paddr == BEMF_CODE_OFFSET)
    || (paddr == BEMF_DIGITAL_OFFSET) || (paddr == STATUS_OFFSET);

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  // Register file, decode and start sequencer
  always_comb
  begin
    state_next = state_reg;
    // Decoded constant tracks the code one cycle later
    state_next.bemfDig = BEMF_DIGITAL_WIDTH'({7'h00, bemf_const_mantissa} << bemf_const_shift);

    // Read data latched in setup so prdata is a flop in access
    if (setupPhase)
    begin
      if (paddr == CTRL_OFFSET)
      begin
        state_next.readData = {22'h000000, state_reg.ctrl};
      end
      else if (paddr == BEMF_CODE_OFFSET)
      begin
        state_next.readData = {25'h0000000, state_reg.bemfCode};
      end
      else if (paddr == BEMF_DIGITAL_OFFSET)
      begin
        state_next.readData = {21'h000000, state_reg.bemfDig};
      end
      else if (paddr == STATUS_OFFSET)
      begin
        state_next.readData = {23'h000000, state_reg.sector, state_reg.rotorClass, state_reg.seqState};
      end
      else
      begin
        // Unmapped reads return zero
        state_next.readData = 32'h00000000;
      end
    end

    // Writes land at the access edge
    if (writeAccess)
    begin
      if (paddr == CTRL_OFFSET)
      begin
        state_next.ctrl = pwdata[CTRL_WIDTH-1:0];
      end
      else if (paddr == BEMF_CODE_OFFSET)
      begin
        state_next.bemfCode = pwdata[BEMF_CODE_WIDTH-1:0];
      end
    end

    // Start sequencer
    case (state_reg.seqState)
      SEQ_POWER_ON:
      begin
        state_next.rotorClass = ROTOR_UNKNOWN;
        if (startEnable)
        begin
          // Skip measurement when detection is off
          state_next.seqState = speedDetectEnable ? SEQ_MEASURE : SEQ_AT_REST;
        end
      end
      SEQ_MEASURE:
      begin
        if (speedValid)
        begin
          if (!rotorFast)
          begin
            state_next.rotorClass = ROTOR_REST;
            state_next.seqState = SEQ_AT_REST;
          end
          else if (spinForward)
          begin
            state_next.rotorClass = ROTOR_FORWARD;
            // Without resync a forward rotor is left to coast down
            state_next.seqState = resyncEnable ? SEQ_CLOSED_LOOP : SEQ_WAIT_STOP;
          end
          else
          begin
            state_next.rotorClass = ROTOR_REVERSE;
            if (reverseEnable)
            begin
              state_next.seqState = SEQ_REVERSE_DRIVE;
            end
            else
            begin
              state_next.seqState = brakeEnable ? SEQ_BRAKE : SEQ_WAIT_STOP;
            end
          end
        end
      end
      SEQ_AT_REST:
      begin
        // Pick how commutation is brought in phase with the rotor
        state_next.alignCount = '0;
        // Phase code 3 has no phase of its own and folds to 0
        state_next.sector = {(state_reg.ctrl[CTRL_ALIGN_PHASE_LSB +: 2] == 2'h3) ? 2'h0
          : state_reg.ctrl[CTRL_ALIGN_PHASE_LSB +: 2], 1'b0};
        state_next.seqState = probeMethod ? SEQ_PROBE : SEQ_ALIGN;
      end
      SEQ_PROBE:
      begin
        // Inductance probe reports the sector it found
        if (probeDone)
        begin
          state_next.sector = probeSector;
          state_next.seqState = SEQ_CLOSED_LOOP;
        end
      end
      SEQ_ALIGN:
      begin
        // Hold the chosen phase until the rotor has settled on it
        if (state_reg.alignCount == ALIGN_COUNT_WIDTH'(ALIGN_CYCLES - 1))
        begin
          state_next.seqState = SEQ_CLOSED_LOOP;
        end
        else
        begin
          state_next.alignCount = state_reg.alignCount + 1'b1;
        end
      end
      SEQ_REVERSE_DRIVE:
      begin
        // Drive on through zero speed, then run forward
        if (zeroCrossed)
        begin
          state_next.seqState = SEQ_CLOSED_LOOP;
        end
      end
      SEQ_BRAKE, SEQ_WAIT_STOP:
      begin
        // Once stopped, follow the at-rest path
        if (rotorStopped)
        begin
          state_next.rotorClass = ROTOR_REST;
          state_next.seqState = SEQ_AT_REST;
        end
      end
      default:
      begin
        state_next.seqState = SEQ_CLOSED_LOOP;
      end
    endcase

    // Clearing start stops the drive from any state
    if (!startEnable)
    begin
      state_next.seqState = SEQ_POWER_ON;
    end
    // Wake from standby or sleep restarts the sequencer
    if (wake)
    begin
      state_next.seqState = SEQ_POWER_ON;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register

  // Registers take reset values, sequencer starts at power-on
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_reg.seqState <= SEQ_POWER_ON;
      state_reg.rotorClass <= ROTOR_UNKNOWN;
      state_reg.ctrl <= CTRL_RESET;
      state_reg.bemfCode <= BEMF_CODE_RESET;
      state_reg.bemfDig <= '0;
      state_reg.sector <= 3'h0;
      state_reg.alignCount <= '0;
      state_reg.readData <= 32'h00000000;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Zero-wait-state slave
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addrMapped;
  assign prdata = state_reg.readData;
  // Drive commands decode the registered state
  assign measureRun = (state_reg.seqState == SEQ_MEASURE);
  assign probeRun = (state_reg.seqState == SEQ_PROBE);
  assign alignRun = (state_reg.seqState == SEQ_ALIGN);
  assign alignPhase = state_reg.sector[2:1];
  assign closedLoop = (state_reg.seqState == SEQ_CLOSED_LOOP);
  // Returned energy is bounded by software's current limit
  assign reverseDriveOn = (state_reg.seqState == SEQ_REVERSE_DRIVE);
  assign brakeOn = (state_reg.seqState == SEQ_BRAKE);
  assign commutationSector = state_reg.sector;
  assign bemfDigital = state_reg.bemfDig;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_code_decode;
    ##1 (bemfDigital == BEMF_DIGITAL_WIDTH'({7'h00, $past(bemf_const_mantissa)} << $past(bemf_const_shift)));
  endproperty
  a_code_decode: assert property (p_code_decode) else $error("decoded constant wrong");

  property p_max_code;
    (state_reg.bemfCode == 7'h7F) ##1 (state_reg.bemfCode == 7'h7F) |-> bemfDigital == BEMF_DIGITAL_MAX;
  endproperty
  a_max_code: assert property (p_max_code) else $error("max code not 1920");

  property p_classify;
    measureRun && speedValid && startEnable && !wake |=> state_reg.rotorClass != ROTOR_UNKNOWN;
  endproperty
  a_classify: assert property (p_classify) else $error("rotor not classified");

  property p_wake;
    wake |=> state_reg.seqState == SEQ_POWER_ON;
  endproperty
  a_wake: assert property (p_wake) else $error("wake did not restart sequencer");

  property p_skip_measure;
    (state_reg.seqState == SEQ_POWER_ON) && startEnable && !speedDetectEnable && !wake
      |=> (state_reg.seqState == SEQ_AT_REST) ##1 (probeRun || alignRun || !startEnable || $past(wake));
  endproperty
  a_skip_measure: assert property (p_skip_measure) else $error("detection not skipped");

  property p_slow_rest;
    measureRun && speedValid && !rotorFast && startEnable && !wake |=> state_reg.seqState == SEQ_AT_REST;
  endproperty
  a_slow_rest: assert property (p_slow_rest) else $error("slow rotor not at rest");

  property p_resync;
    measureRun && speedValid && rotorFast && spinForward && resyncEnable && startEnable && !wake |=> closedLoop;
  endproperty
  a_resync: assert property (p_resync) else $error("no resync");

  property p_reverse;
    measureRun && speedValid && rotorFast && !spinForward && startEnable && !wake
      |=> (reverseDriveOn == $past(reverseEnable)) && (brakeOn == ($past(brakeEnable) && !$past(reverseEnable)));
  endproperty
  a_reverse: assert property (p_reverse) else $error("reverse action wrong");

  property p_stop_rest;
    (brakeOn || state_reg.seqState == SEQ_WAIT_STOP) && rotorStopped && startEnable && !wake
      |=> state_reg.seqState == SEQ_AT_REST;
  endproperty
  a_stop_rest: assert property (p_stop_rest) else $error("stopped rotor not at rest");

  property p_probe_sector;
    probeRun && probeDone && startEnable && !wake |=> closedLoop && (commutationSector == $past(probeSector));
  endproperty
  a_probe_sector: assert property (p_probe_sector) else $error("probe sector not loaded");

  property p_align_hold;
    $rose(alignRun) |-> alignRun [*8];
  endproperty
  a_align_hold: assert property (p_align_hold) else $error("align released early");

  c_resync: cover property (measureRun ##1 closedLoop);
  c_align: cover property (alignRun ##1 closedLoop);
  c_brake: cover property (brakeOn ##[1:50] probeRun);

endmodule : sensorless_start_condition_logic

`default_nettype wire

// ### verification/motor_model.sv
// Behavioural motor winding model for the start-logic bench.
// Assumes the run outputs of the design are decodes of its state flop.
`timescale 1ns/1ps
`default_nettype none
module motor_model
  import start_logic_pkg::*;
#(parameter int LAG = 3)
(
  // Clock
  input wire logic clk,
  // Drive modes: measure, probe, reverse, brake
  input wire logic [3:0] runs,
  // Scenario setup
  input wire logic [SPEED_WIDTH-1:0] speedSet,
  input wire logic fwdSet,
  // Sensing returned to the design
  output logic speedValid,
  output logic [SPEED_WIDTH-1:0] measuredSpeed,
  output logic spinForward,
  output logic rotorStopped,
  output logic zeroCrossed,
  output logic probeDone,
  output logic [2:0] probeSector
);
  logic [3:0] lastRuns = 4'h0; // Mode seen last cycle
  logic [7:0] age = 8'h00; // Cycles spent in the mode
  logic [7:0] curAge; // Age restarted on a mode change

  ////////////////////////////////////////////////////////////
  // Age restarts at once, so a stale count never fires early
  assign curAge = (runs != lastRuns) ? 8'h00 : age;
  always @(posedge clk)
  begin
    lastRuns <= runs;
    age <= (curAge == 8'hFF) ? curAge : curAge + 8'h01;
  end

  ////////////////////////////////////////////////////////////
  // Outside a valid sample the lines show the inverse value
  assign speedValid = runs[3] && curAge == 8'(LAG);
  assign measuredSpeed = speedValid ? speedSet : ~speedSet;
  assign spinForward = speedValid ? fwdSet : ~fwdSet;
  assign probeDone = runs[2] && curAge == 8'(LAG);
  assign probeSector = probeDone ? 3'h5 : 3'h2;
  // No winding current here: host is taken to have set a current limit
  assign zeroCrossed = runs[1] && curAge >= 8'(LAG);
  // Braked or coasting rotor stops after a while
  assign rotorStopped = runs[3:2] == 2'h0 && curAge >= 8'(LAG);
endmodule : motor_model
`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench for the start-condition logic.
// Assumes the package and the motor model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import start_logic_pkg::*;
  // Row: control, speed, direction, seen runs, class, sector
  typedef struct packed {
    logic [9:0] ctrl;
    logic [15:0] spd;
    logic fwd;
    logic [4:0] seen;
    logic [2:0] cls;
    logic [3:0] sec;
  } row_type;
  logic clk, srst, psel, penable, pwrite, pready, pslverr, wake, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic speedValid, spinForward, rotorStopped, zeroCrossed, probeDone, fwdSet;
  logic [15:0] measuredSpeed, speedSet;
  logic [2:0] probeSector, commutationSector;
  logic measureRun, probeRun, alignRun, closedLoop, reverseDriveOn, brakeOn;
  logic [1:0] alignPhase;
  logic [10:0] bemfDigital;
  logic [4:0] seen;
  int nFail = 0;
  int totalChecks = 0;
  int cycles = 0;
  // Class 4 and sector 8 mean not checked; a rotor that came to a stop reports rest
  row_type rows [13] = '{
    '{10'h027, 16'h003F, 1'b1, 5'h18, 3'h1, 4'h5},
    '{10'h027, 16'h0040, 1'b1, 5'h10, 3'h2, 4'h8},
    '{10'h081, 16'h0000, 1'b1, 5'h04, 3'h4, 4'h4},
    '{10'h0C1, 16'h0000, 1'b1, 5'h04, 3'h4, 4'h0},
    '{10'h00B, 16'h0100, 1'b0, 5'h12, 3'h3, 4'h8},
    '{10'h033, 16'h0100, 1'b0, 5'h19, 3'h1, 4'h5},
    '{10'h023, 16'h0100, 1'b0, 5'h18, 3'h1, 4'h5},
    '{10'h023, 16'h0100, 1'b1, 5'h18, 3'h1, 4'h5},
    '{10'h127, 16'h007F, 1'b1, 5'h18, 3'h1, 4'h5},
    '{10'h327, 16'h01FF, 1'b1, 5'h18, 3'h1, 4'h5},
    '{10'h327, 16'h0200, 1'b1, 5'h10, 3'h2, 4'h8},
    '{10'h007, 16'h0100, 1'b1, 5'h10, 3'h2, 4'h8},
    '{10'h227, 16'h0100, 1'b1, 5'h10, 3'h2, 4'h8}
  };
  logic [6:0] codes [7] = '{7'h01, 7'h0F, 7'h18, 7'h2A, 7'h4F, 7'h5A, 7'h7F};

  ////////////////////////////////////////////////////////////
  // Design and far-side model
  sensorless_start_condition_logic dut (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .wake(wake),
    .speedValid(speedValid), .measuredSpeed(measuredSpeed), .spinForward(spinForward),
    .rotorStopped(rotorStopped), .zeroCrossed(zeroCrossed), .probeDone(probeDone),
    .probeSector(probeSector), .measureRun(measureRun), .probeRun(probeRun), .alignRun(alignRun),
    .alignPhase(alignPhase), .closedLoop(closedLoop), .reverseDriveOn(reverseDriveOn),
    .brakeOn(brakeOn), .commutationSector(commutationSector), .bemfDigital(bemfDigital));
  motor_model motor (.clk(clk), .runs({measureRun, probeRun, reverseDriveOn, brakeOn}),
    .speedSet(speedSet), .fwdSet(fwdSet), .speedValid(speedValid),
    .measuredSpeed(measuredSpeed), .spinForward(spinForward), .rotorStopped(rotorStopped),
    .zeroCrossed(zeroCrossed), .probeDone(probeDone), .probeSector(probeSector));

  ////////////////////////////////////////////////////////////
  // Clock, run monitor and hang guard
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    seen <= seen | {measureRun, probeRun, alignRun, reverseDriveOn, brakeOn};
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      nFail = nFail + 1;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////
  // One APB transfer; holds the request until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      nFail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Bounded wait for closed loop
  task automatic waitLoop();
    int n;
    n = 0;
    #1;
    while (closedLoop !== 1'b1 && n < 3000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(closedLoop, 32'h1);
  endtask : waitLoop

  task automatic conclude();
    $display("checks %0d mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {srst, psel, penable, pwrite, paddr, pwdata, wake, speedSet, fwdSet, seen} = '0;
    srst = 1'b1;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    // Register rows: table loop
    foreach (rows[i])
    begin
      apb(1'b1, CTRL_OFFSET, 32'h0);
      @(posedge clk);
      speedSet <= rows[i].spd;
      fwdSet <= rows[i].fwd;
      #1 seen = 5'h0;
      apb(1'b1, CTRL_OFFSET, 32'(rows[i].ctrl));
      waitLoop();
      chk(seen, rows[i].seen);
      apb(1'b0, STATUS_OFFSET, 32'h0);
      if (rows[i].cls != 3'h4)
        chk(rd[5:0], {rows[i].cls[1:0], 4'h5});
      if (rows[i].sec != 4'h8)
      begin
        chk(commutationSector, rows[i].sec[2:0]);
        chk(alignPhase, rows[i].sec[2:1]);
      end
      $display("row %0d done", i);
    end
    // Wake forces a restart from the initial state
    @(posedge clk);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    #1 chk({closedLoop, measureRun}, 32'h0);
    waitLoop();
    $display("wake test done");
    // Reset in mid-run, then reset values
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    #1 chk({closedLoop, bemfDigital}, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk(rd, 32'h0);
    end
    $display("reset test done");
    // Unmapped place and read-only register
    apb(1'b1, 12'h010, 32'hFFFFFFFF);
    chk(err, 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h0);
    chk(err, 32'h1);
    apb(1'b1, BEMF_DIGITAL_OFFSET, 32'h7FF);
    apb(1'b0, BEMF_DIGITAL_OFFSET, 32'h0);
    chk(rd, 32'h0);
    $display("access test done");
    // Constant code: shift above mantissa
    foreach (codes[i])
    begin
      apb(1'b1, BEMF_CODE_OFFSET, 32'(codes[i]));
      apb(1'b0, BEMF_DIGITAL_OFFSET, 32'h0);
      chk(rd, 32'(codes[i][3:0]) << codes[i][6:4]);
      chk(bemfDigital, 32'(codes[i][3:0]) << codes[i][6:4]);
    end
    chk(bemfDigital, 32'd1920);
    $display("code test done");
    conclude();
  end
endmodule : testbench
`default_nettype wire
